/* File: rtl/skhc_pkg.sv */
// Shared constants, types and helpers of the scale key and host command block.
// Assumes a single 20 MHz clock for all users of the package.
package skhc_pkg;
    localparam int CLK_HZ = 20_000_000;
    localparam int MS_PER_S = 1000;
    localparam int OFF_HOLD_MS = 5000;
    localparam int OFF_HOLD_CYC = CLK_HZ / MS_PER_S * OFF_HOLD_MS;
    localparam int MEAS_PER_S = 10;
    localparam int MEAS_CYC = CLK_HZ / MEAS_PER_S;
    localparam int BAUD_1200 = 1200;
    localparam int BAUD_2400 = 2400;
    localparam int BAUD_4800 = 4800;
    localparam int BAUD_9600 = 9600;
    localparam int DIV_W = 15;
    localparam logic [7:0] CH_P = 8'h50;
    localparam logic [7:0] CH_Z = 8'h5A;
    localparam logic [7:0] CH_T = 8'h54;
    localparam logic [7:0] CH_G = 8'h47;
    localparam logic [7:0] CH_N = 8'h4E;
    localparam logic [7:0] CH_C = 8'h43;
    localparam int K_ZERO = 0;
    localparam int K_TARE = 1;
    localparam int K_VIEW = 2;
    localparam int K_PRINT = 3;
    localparam int K_UNIT = 4;
    localparam int S_RXD = 5;
    localparam logic [5:0] SYNC_RST = 6'h20;
    typedef enum logic [1:0] {SKHC_B1200 = 2'b00, SKHC_B2400 = 2'b01,
        SKHC_B4800 = 2'b10, SKHC_B9600 = 2'b11} skhc_baud_t;
    typedef enum logic [1:0] {SKHC_8N1 = 2'b00, SKHC_7O1 = 2'b01,
        SKHC_7E1 = 2'b10, SKHC_7N2 = 2'b11} skhc_frame_t;
    typedef enum logic {SKHC_DEMAND = 1'b0, SKHC_CONT = 1'b1} skhc_smode_t;
    typedef enum logic [2:0] {SKHC_IDLE = 3'b000, SKHC_START = 3'b001, SKHC_DATA = 3'b010,
        SKHC_PAR = 3'b011, SKHC_STOP = 3'b100} skhc_ser_t;

    function automatic logic [DIV_W-1:0] baud_div(skhc_baud_t b);
        logic [DIV_W-1:0] d;
        d = DIV_W'(CLK_HZ / BAUD_9600);
        case (b)
            SKHC_B1200: d = DIV_W'(CLK_HZ / BAUD_1200);
            SKHC_B2400: d = DIV_W'(CLK_HZ / BAUD_2400);
            SKHC_B4800: d = DIV_W'(CLK_HZ / BAUD_4800);
            default: d = DIV_W'(CLK_HZ / BAUD_9600);
        endcase
        return d;
    endfunction

    function automatic logic [3:0] frame_bits(skhc_frame_t f);
        return (f == SKHC_8N1) ? 4'h8 : 4'h7;
    endfunction

    function automatic logic frame_par(skhc_frame_t f);
        return (f == SKHC_7O1) || (f == SKHC_7E1);
    endfunction

    function automatic logic [3:0] frame_stops(skhc_frame_t f);
        return (f == SKHC_7N2) ? 4'h2 : 4'h1;
    endfunction
endpackage

/* File: rtl/skhc_top.sv */
// Key and host command interpreter of a battery weighing indicator.
// Assumes status inputs come from logic on clk; keys and rxd are raw pins.
// Function
// R1: Five-second zero hold powers off; short press zeroes
// R2: Key zero needs gross, range, stable, no overload
// R3: View key toggles gross/net only with tare
// R4: Key tare needs positive gross, stable, no overload
// R5: Print key while off powers on
// R6: Print key sends only when stable, not overloaded
// R7: Accepted tare shows zero and lights net
// R8: Unit key toggles pounds and kilograms when enabled
// R9: Demand mode: host commands plus print key
// R10: Host P sends reading unless motion or overload
// R11: Host Z zeroes under gross, range, stable conditions
// R12: Host T tares unless motion, overload, negative gross
// R13: Host G goes gross only from net
// R14: Host N goes net from gross with tare
// R15: Host C advances to next unit
// R16: Ticket mode uses rxd as clear-to-send
// R17: Ticket omits tare and net without tare
// R18: Ticket omits ID line when disabled
// R19: Continuous mode sends a record per update
// R20: Full duplex at 1200 to 9600 baud
// R21: Four character frame formats
// R22: Ten measurements per second update cadence
// R23: Refused request changes nothing, sends nothing
// R24: Ticket mode holds next character while clear-to-send low
`timescale 1ns/1ns
`default_nettype none
module skhc_top #(
    parameter int HOLD_CYCLES = skhc_pkg::OFF_HOLD_CYC,
    parameter int MEAS_CYCLES = skhc_pkg::MEAS_CYC
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Front-panel keys, high while pressed
    input wire logic zero_key,
    input wire logic tare_key,
    input wire logic view_key,
    input wire logic print_key,
    input wire logic unit_toggle_key,
    // Weighing status
    input wire logic scale_stable,
    input wire logic over_pos,
    input wire logic over_neg,
    input wire logic gross_above_zero,
    input wire logic gross_negative,
    input wire logic in_zero_range,
    // Settings
    input wire skhc_pkg::skhc_smode_t serial_mode_selector,
    input wire logic ticket_enable_setting,
    input wire logic id_field_setting,
    input wire logic unit_switch_enable,
    input wire skhc_pkg::skhc_baud_t baud_sel,
    input wire skhc_pkg::skhc_frame_t frame_sel,
    // Serial line
    input wire logic rxd,
    output logic txd,
    // Record bytes from the formatter
    input wire logic [7:0] out_byte,
    input wire logic out_valid,
    output logic out_ready,
    // Weighing state and requests
    output logic power_on,
    output logic net_mode,
    output logic tare_valid,
    output logic unit_kg,
    output logic zero_pulse,
    output logic tare_pulse,
    output logic record_req,
    output logic meas_tick,
    output logic ticket_id_line,
    output logic ticket_tare_lines
);
    import skhc_pkg::*;

    localparam int HW = $clog2(HOLD_CYCLES);
    localparam int MW = $clog2(MEAS_CYCLES);
    localparam logic [HW-1:0] HOLD_LAST = HW'(HOLD_CYCLES - 1);
    localparam logic [MW-1:0] MEAS_LAST = MW'(MEAS_CYCLES - 1);

    if (HOLD_CYCLES < 2 || MEAS_CYCLES < 2)
    begin : g_chk
        $error("skhc_top: hold and measurement counts must be at least 2");
    end

    logic [5:0] meta;
    logic [5:0] sync;
    logic [4:0] key_prev;
    logic [4:0] key_rise;
    logic [HW-1:0] hold_cnt;
    logic [MW-1:0] meas_cnt;
    logic cmd_valid;
    logic [7:0] cmd;
    logic tx_idle;
    logic tx_go;
    logic ok;
    logic host;
    logic zero_rel;
    logic hold_fire;
    logic wake;
    logic cts_ok;
    logic do_zero;
    logic do_tare;
    logic do_gross;
    logic do_net;
    logic do_view;
    logic do_unit;
    logic do_print;
    logic cont_fire;
    logic cmd_ok;

    // Keys and rxd cross from the pins through two flops each.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meta <= SYNC_RST;
            sync <= SYNC_RST;
            key_prev <= '0;
        end
        else
        begin
            meta <= {rxd, unit_toggle_key, print_key, view_key, tare_key, zero_key};
            sync <= meta;
            key_prev <= sync[4:0];
        end
    end

    assign key_rise = sync[4:0] & ~key_prev;
    assign cts_ok = !ticket_enable_setting || sync[S_RXD]; // R16
    assign tx_go = out_valid && out_ready;

    always_comb
    begin
        ok = scale_stable && !over_pos && !over_neg;
        host = cmd_valid && power_on && !ticket_enable_setting
            && serial_mode_selector == SKHC_DEMAND; // R9
        zero_rel = power_on && key_prev[K_ZERO] && !sync[K_ZERO]; // R1
        hold_fire = power_on && sync[K_ZERO] && hold_cnt == HOLD_LAST; // R1
        wake = !power_on && key_rise[K_PRINT]; // R5
        do_zero = ok && !net_mode && in_zero_range
            && (zero_rel || (host && cmd == CH_Z)); // R2 R11
        do_tare = power_on && ok && ((key_rise[K_TARE] && gross_above_zero) // R4
            || (host && cmd == CH_T && !gross_negative)); // R12
        do_gross = host && cmd == CH_G && ok && net_mode; // R13
        do_net = host && cmd == CH_N && ok && !net_mode && tare_valid; // R14
        do_view = power_on && key_rise[K_VIEW] && tare_valid; // R3
        do_unit = (power_on && key_rise[K_UNIT] && unit_switch_enable) // R8
            || (host && cmd == CH_C); // R15
        cont_fire = meas_tick && power_on && !ticket_enable_setting
            && serial_mode_selector == SKHC_CONT; // R19
        do_print = (power_on && key_rise[K_PRINT] && ok) // R6
            || (host && cmd == CH_P && ok) || cont_fire; // R10
        cmd_ok = do_zero || do_tare || do_gross || do_net
            || (host && cmd == CH_C) || (host && cmd == CH_P && ok);
    end

    // The hold count only runs while powered; zero_rel also needs power_on, so a release after switch-off zeroes nothing.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            hold_cnt <= '0;
        else if (!power_on || !sync[K_ZERO])
            hold_cnt <= '0;
        else if (hold_cnt != HOLD_LAST)
            hold_cnt <= hold_cnt + 1'b1;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            power_on <= 1'b1;
        else if (hold_fire)
            power_on <= 1'b0; // R1
        else if (wake)
            power_on <= 1'b1; // R5
    end

    // A tare always lands in net mode so the display reads zero net at once.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            net_mode <= 1'b0;
        else if (do_tare || do_net)
            net_mode <= 1'b1; // R7 R14
        else if (do_gross)
            net_mode <= 1'b0; // R13
        else if (do_view)
            net_mode <= !net_mode; // R3
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            tare_valid <= 1'b0;
        else if (do_tare)
            tare_valid <= 1'b1; // R7
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            unit_kg <= 1'b0;
        else if (do_unit)
            unit_kg <= !unit_kg; // R8 R15
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            zero_pulse <= 1'b0;
            tare_pulse <= 1'b0;
            record_req <= 1'b0;
        end
        else
        begin
            zero_pulse <= do_zero; // R23
            tare_pulse <= do_tare;
            record_req <= do_print; // R23
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ticket_id_line <= 1'b0;
            ticket_tare_lines <= 1'b0;
        end
        else
        begin
            ticket_id_line <= id_field_setting; // R18
            ticket_tare_lines <= tare_valid; // R17
        end
    end

    // Free-running measurement cadence that paces continuous output.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            meas_cnt <= '0;
            meas_tick <= 1'b0;
        end
        else
        begin
            meas_cnt <= (meas_cnt == MEAS_LAST) ? '0 : meas_cnt + 1'b1; // R22
            meas_tick <= (meas_cnt == MEAS_LAST);
        end
    end

    // Ready drops for the cycle after a hand-over, covering the transmitter's idle lag.
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            out_ready <= 1'b0;
        else
            out_ready <= power_on && tx_idle && cts_ok && !tx_go; // R24
    end

    skhc_uart_tx u_tx (
        .clk(clk),
        .rst_n(rst_n),
        .go(tx_go),
        .data(out_byte),
        .frame(frame_sel),
        .baud(baud_sel),
        .idle(tx_idle),
        .txd(txd)
    ); // R20 R21

    skhc_uart_rx u_rx (
        .clk(clk),
        .rst_n(rst_n),
        .rxd(sync[S_RXD]),
        .frame(frame_sel),
        .baud(baud_sel),
        .valid(cmd_valid),
        .data(cmd)
    ); // R20 R21

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    sequence held_out_s;
        power_on && sync[K_ZERO] && hold_cnt == HOLD_LAST;
    endsequence

    sequence wake_s;
        !power_on && key_rise[K_PRINT];
    endsequence

    hold_off_a: assert property (held_out_s |=> !power_on && !zero_pulse) // R1
        else $error("zero hold did not power off");
    zero_cond_a: assert property (zero_pulse |-> $past(ok) && !$past(net_mode) // R2
        && $past(in_zero_range))
        else $error("zero accepted against its conditions");
    view_block_a: assert property (key_rise[K_VIEW] && !tare_valid && !cmd_valid // R3
        && !key_rise[K_TARE] |=> $stable(net_mode))
        else $error("view toggled without tare");
    tare_net_a: assert property (tare_pulse |-> net_mode && tare_valid // R7
        && $past(ok))
        else $error("tare did not show net");
    wake_on_a: assert property (wake_s |=> power_on && !record_req) // R5
        else $error("print key did not power on");
    print_gate_a: assert property (record_req && !$past(cont_fire) |-> $past(ok)) // R6
        else $error("record sent while unstable");
    cont_rec_a: assert property (cont_fire |=> record_req ##1 !record_req) // R19
        else $error("continuous record missing");
    cts_hold_a: assert property (ticket_enable_setting && !sync[S_RXD] // R24
        |=> !out_ready)
        else $error("ready while clear-to-send low");
    refuse_a: assert property (host && !cmd_ok && key_rise == '0 && !zero_rel // R23
        && !cont_fire |=> $stable(net_mode) && $stable(tare_valid) && $stable(unit_kg)
        && !zero_pulse && !record_req)
        else $error("refused command had effect");
    meas_gap_a: assert property (meas_tick |=> !meas_tick) // R22
        else $error("measurement ticks too close");
endmodule
`default_nettype wire

/* File: rtl/skhc_uart_rx.sv */
// Serial receiver; delivers one character pulse per good frame.
// Assumes rxd is already synchronised; bad parity or stop bit drops the character.
`timescale 1ns/1ns
`default_nettype none
module skhc_uart_rx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Line and format
    input wire logic rxd,
    input wire skhc_pkg::skhc_frame_t frame,
    input wire skhc_pkg::skhc_baud_t baud,
    // Received character
    output logic valid,
    output logic [7:0] data
);
    import skhc_pkg::*;
    skhc_ser_t state;
    skhc_frame_t fr;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] dv;
    logic [7:0] sh;
    logic [3:0] idx;
    logic perr;

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= SKHC_IDLE;
            fr <= SKHC_8N1;
            cnt <= '0;
            dv <= '0;
            sh <= '0;
            idx <= '0;
            perr <= 1'b0;
            valid <= 1'b0;
            data <= '0;
        end
        else
        begin
            valid <= 1'b0;
            if (state == SKHC_IDLE)
            begin
                if (!rxd)
                begin
                    fr <= frame;
                    dv <= baud_div(baud);
                    cnt <= baud_div(baud) >> 1;
                    sh <= '0;
                    perr <= 1'b0;
                    state <= SKHC_START;
                end
            end
            else if (cnt != '0)
                cnt <= cnt - 1'b1;
            else
            begin
                cnt <= dv - 1'b1;
                unique case (state)
                    SKHC_START:
                    begin
                        state <= rxd ? SKHC_IDLE : SKHC_DATA;
                        idx <= '0;
                    end
                    SKHC_DATA:
                    begin
                        sh[idx[2:0]] <= rxd;
                        idx <= idx + 1'b1;
                        if (idx == frame_bits(fr) - 1'b1)
                            state <= frame_par(fr) ? SKHC_PAR : SKHC_STOP;
                    end
                    SKHC_PAR:
                    begin
                        perr <= (^sh[6:0] ^ (fr == SKHC_7O1)) != rxd;
                        state <= SKHC_STOP;
                    end
                    SKHC_STOP:
                    begin
                        valid <= rxd && !perr;
                        data <= sh;
                        state <= SKHC_IDLE;
                    end
                    default: state <= SKHC_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: rtl/skhc_uart_tx.sv */
// Serial transmitter for one character in any of the four frame formats.
// Assumes go is only raised while idle is high; rate and frame are latched per character.
`timescale 1ns/1ns
`default_nettype none
module skhc_uart_tx (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Character request
    input wire logic go,
    input wire logic [7:0] data,
    input wire skhc_pkg::skhc_frame_t frame,
    input wire skhc_pkg::skhc_baud_t baud,
    output logic idle,
    // Line
    output logic txd
);
    import skhc_pkg::*;
    skhc_ser_t state;
    skhc_frame_t fr;
    logic [DIV_W-1:0] cnt;
    logic [DIV_W-1:0] dv;
    logic [7:0] sh;
    logic [3:0] idx;
    logic par;

    assign idle = (state == SKHC_IDLE);

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= SKHC_IDLE;
            fr <= SKHC_8N1;
            cnt <= '0;
            dv <= '0;
            sh <= '0;
            idx <= '0;
            par <= 1'b0;
            txd <= 1'b1;
        end
        else if (state == SKHC_IDLE)
        begin
            if (go)
            begin
                fr <= frame;
                sh <= data;
                par <= ^data[6:0] ^ (frame == SKHC_7O1);
                dv <= baud_div(baud);
                cnt <= baud_div(baud) - 1'b1;
                state <= SKHC_START;
                txd <= 1'b0;
            end
        end
        else if (cnt != '0)
            cnt <= cnt - 1'b1;
        else
        begin
            cnt <= dv - 1'b1;
            // Codes above the stop state cannot occur; the default recovers to idle.
            unique case (state)
                SKHC_START:
                begin
                    state <= SKHC_DATA;
                    txd <= sh[0];
                    idx <= '0;
                end
                SKHC_DATA:
                    if (idx == frame_bits(fr) - 1'b1)
                    begin
                        state <= frame_par(fr) ? SKHC_PAR : SKHC_STOP;
                        txd <= frame_par(fr) ? par : 1'b1;
                        idx <= '0;
                    end
                    else
                    begin
                        idx <= idx + 1'b1;
                        sh <= {1'b0, sh[7:1]};
                        txd <= sh[1];
                    end
                SKHC_PAR:
                begin
                    state <= SKHC_STOP;
                    txd <= 1'b1;
                end
                SKHC_STOP:
                    if (idx == frame_stops(fr) - 1'b1)
                        state <= SKHC_IDLE;
                    else
                        idx <= idx + 1'b1;
                default: state <= SKHC_IDLE;
            endcase
        end
    end
endmodule
`default_nettype wire

/* File: test/skhc_host_model.sv */
// Behavioural host computer or printer on the far side of the serial port.
// Assumes 8N1 framing at one bit time of BIT_CYC clocks, matching the design's setting.
`timescale 1ns/1ns
`default_nettype none
module skhc_host_model #(
    parameter int BIT_CYC = 2083
) (
    // Clock
    input wire logic clk,
    // Serial lines seen from the host
    input wire logic txd,
    output logic rxd,
    // Last character heard from the indicator
    output logic [7:0] rx_byte,
    output logic [7:0] rx_count
);
    initial
    begin
        rxd = 1'b1;
        rx_byte = 8'h00;
        rx_count = 8'h00;
    end

    // Start bit, eight data bits LSB first, one stop bit at the shared rate.
    task automatic send_char(input logic [7:0] ch);
        integer i;
        @(posedge clk);
        #2 rxd = 1'b0;
        repeat (BIT_CYC) @(posedge clk);
        for (i = 0; i < 8; i++)
        begin
            #2 rxd = ch[i];
            repeat (BIT_CYC) @(posedge clk);
        end
        #2 rxd = 1'b1;
        repeat (BIT_CYC) @(posedge clk);
    endtask

    // A printer's ready output is wired to the indicator's receive pin.
    task automatic set_cts(input logic level);
        @(posedge clk);
        #2 rxd = level;
    endtask

    // Sampling at mid bit tolerates the design's rounded-down divisor.
    always
    begin : rx_loop
        logic [7:0] b;
        @(negedge txd);
        repeat (BIT_CYC / 2) @(posedge clk);
        for (int i = 0; i < 8; i++)
        begin
            repeat (BIT_CYC) @(posedge clk);
            b[i] = txd;
        end
        repeat (BIT_CYC) @(posedge clk);
        rx_byte = b;
        rx_count = rx_count + 8'h01;
    end
endmodule
`default_nettype wire

/* File: test/test_scale_key_and_host_commands.sv */
// Self-checking bench for the key and host command interpreter.
// Assumes the host model above stands on the serial lines; counts are shortened by parameters.
`timescale 1ns/1ns
`default_nettype none
module test_scale_key_and_host_commands import skhc_pkg::*;;
    localparam int HOLD_C = 20;
    localparam int MEAS_C = 16;
    localparam int BIT_C = CLK_HZ / BAUD_9600;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [4:0] keys = 5'h00;
    logic scale_stable = 1'b1, over_pos = 1'b0, over_neg = 1'b0;
    logic gross_above_zero = 1'b1, gross_negative = 1'b0, in_zero_range = 1'b1;
    skhc_smode_t serial_mode_selector = SKHC_DEMAND;
    logic ticket_enable_setting = 1'b0, id_field_setting = 1'b0, unit_switch_enable = 1'b0;
    skhc_baud_t baud_sel = SKHC_B9600;
    skhc_frame_t frame_sel = SKHC_8N1;
    logic [7:0] out_byte = 8'h00;
    logic out_valid = 1'b0;
    logic rxd, txd, out_ready, power_on, net_mode, tare_valid, unit_kg;
    logic zero_pulse, tare_pulse, record_req, meas_tick, ticket_id_line, ticket_tare_lines;
    logic [7:0] rx_byte, rx_count;
    int n_fail = 0, n_checks = 0, zp_cnt = 0, tp_cnt = 0, rr_cnt = 0, mt_cnt = 0;
    int z0, t0, p0, m0;
    bit taken;
    // Columns: key, stable, overload, gross above zero, in range, unit enable,
    // then expected net, tare valid, kg, zero pulses, tare pulses, records.
    int rows [16][12] = '{
        '{2, 1, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0}, '{1, 0, 0, 1, 1, 0, 0, 0, 0, 0, 0, 0},
        '{1, 1, 0, 0, 1, 0, 0, 0, 0, 0, 0, 0}, '{1, 1, 1, 1, 1, 0, 0, 0, 0, 0, 0, 0},
        '{1, 1, 0, 1, 1, 0, 1, 1, 0, 0, 1, 0}, '{0, 1, 0, 1, 1, 0, 1, 1, 0, 0, 0, 0},
        '{2, 1, 0, 1, 1, 0, 0, 1, 0, 0, 0, 0}, '{0, 1, 0, 1, 0, 0, 0, 1, 0, 0, 0, 0},
        '{0, 0, 0, 1, 1, 0, 0, 1, 0, 0, 0, 0}, '{0, 1, 2, 1, 1, 0, 0, 1, 0, 0, 0, 0},
        '{0, 1, 0, 1, 1, 0, 0, 1, 0, 1, 0, 0}, '{3, 1, 0, 1, 1, 0, 0, 1, 0, 0, 0, 1},
        '{3, 0, 0, 1, 1, 0, 0, 1, 0, 0, 0, 0}, '{3, 1, 2, 1, 1, 0, 0, 1, 0, 0, 0, 0},
        '{4, 1, 0, 1, 1, 0, 0, 1, 0, 0, 0, 0}, '{4, 1, 0, 1, 1, 1, 0, 1, 1, 0, 0, 0}};

    always #25 clk = ~clk;

    skhc_top #(.HOLD_CYCLES(HOLD_C), .MEAS_CYCLES(MEAS_C)) skhc_top_inst (
        .clk(clk), .rst_n(rst_n), .zero_key(keys[K_ZERO]), .tare_key(keys[K_TARE]),
        .view_key(keys[K_VIEW]), .print_key(keys[K_PRINT]), .unit_toggle_key(keys[K_UNIT]),
        .scale_stable(scale_stable), .over_pos(over_pos), .over_neg(over_neg),
        .gross_above_zero(gross_above_zero), .gross_negative(gross_negative),
        .in_zero_range(in_zero_range), .serial_mode_selector(serial_mode_selector),
        .ticket_enable_setting(ticket_enable_setting), .id_field_setting(id_field_setting),
        .unit_switch_enable(unit_switch_enable), .baud_sel(baud_sel), .frame_sel(frame_sel),
        .rxd(rxd), .txd(txd), .out_byte(out_byte), .out_valid(out_valid),
        .out_ready(out_ready), .power_on(power_on), .net_mode(net_mode),
        .tare_valid(tare_valid), .unit_kg(unit_kg), .zero_pulse(zero_pulse),
        .tare_pulse(tare_pulse), .record_req(record_req), .meas_tick(meas_tick),
        .ticket_id_line(ticket_id_line), .ticket_tare_lines(ticket_tare_lines));

    skhc_host_model #(.BIT_CYC(BIT_C)) skhc_host_model_inst (
        .clk(clk), .txd(txd), .rxd(rxd), .rx_byte(rx_byte), .rx_count(rx_count));

    // Pulses are counted on the falling edge, away from the edge where windows open.
    always @(negedge clk)
    begin
        zp_cnt += (zero_pulse === 1'b1);
        tp_cnt += (tare_pulse === 1'b1);
        rr_cnt += (record_req === 1'b1);
        mt_cnt += (meas_tick === 1'b1);
    end

    task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
            n_fail++;
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic timed_out(input string what);
        $display("MISMATCH %s expected done seen timeout", what);
        n_fail++;
        give_verdict();
    endtask

    // Clean edges only: the keys are not debounced.
    task automatic press(input int k, input int n);
        @(posedge clk);
        #2 keys[k] = 1'b1;
        repeat (n) @(posedge clk);
        #2 keys[k] = 1'b0;
        repeat (8) @(posedge clk);
    endtask

    task automatic snap();
        z0 = zp_cnt;
        t0 = tp_cnt;
        p0 = rr_cnt;
        m0 = mt_cnt;
    endtask

    initial
    begin
        repeat (6) @(posedge clk);
        #2 rst_n = 1'b1;
        for (int r = 0; r < 16; r++)
        begin
            @(posedge clk);
            #2 scale_stable = rows[r][1][0];
            over_pos = rows[r][2][0];
            over_neg = rows[r][2][1];
            gross_above_zero = rows[r][3][0];
            in_zero_range = rows[r][4][0];
            unit_switch_enable = rows[r][5][0];
            snap();
            press(rows[r][0], 4);
            cmp("net_mode", 8'(rows[r][6]), {7'h00, net_mode});
            cmp("tare_valid", 8'(rows[r][7]), {7'h00, tare_valid});
            cmp("unit_kg", 8'(rows[r][8]), {7'h00, unit_kg});
            cmp("zero_pulses", 8'(rows[r][9]), 8'(zp_cnt - z0));
            cmp("tare_pulses", 8'(rows[r][10]), 8'(tp_cnt - t0));
            cmp("records", 8'(rows[r][11]), 8'(rr_cnt - p0));
        end
        $display("test key table done");
        snap();
        press(K_ZERO, HOLD_C + 10);
        cmp("power_on", 8'h00, {7'h00, power_on});
        cmp("zero_pulses", 8'h00, 8'(zp_cnt - z0));
        press(K_PRINT, 4);
        cmp("power_on", 8'h01, {7'h00, power_on});
        cmp("records", 8'h00, 8'(rr_cnt - p0));
        $display("test power key done");
        snap();
        repeat (4 * MEAS_C) @(posedge clk);
        cmp("records", 8'h00, 8'(rr_cnt - p0));
        cmp("ticks", 8'h04, 8'(mt_cnt - m0));
        #2 serial_mode_selector = SKHC_CONT;
        repeat (4) @(posedge clk);
        snap();
        repeat (4 * MEAS_C) @(posedge clk);
        cmp("records", 8'h04, 8'(rr_cnt - p0));
        #2 serial_mode_selector = SKHC_DEMAND;
        repeat (4) @(posedge clk);
        $display("test continuous done");
        skhc_host_model_inst.send_char(CH_N);
        repeat (6) @(posedge clk);
        cmp("net_mode", 8'h01, {7'h00, net_mode});
        skhc_host_model_inst.send_char(CH_C);
        repeat (6) @(posedge clk);
        cmp("unit_kg", 8'h00, {7'h00, unit_kg});
        snap();
        skhc_host_model_inst.send_char(CH_P);
        repeat (6) @(posedge clk);
        cmp("records", 8'h01, 8'(rr_cnt - p0));
        $display("test host commands done");
        #2 rst_n = 1'b0;
        repeat (2) @(posedge clk);
        cmp("power_on", 8'h01, {7'h00, power_on});
        cmp("tare_valid", 8'h00, {7'h00, tare_valid});
        cmp("net_mode", 8'h00, {7'h00, net_mode});
        cmp("txd", 8'h01, {7'h00, txd});
        #2 rst_n = 1'b1;
        $display("test reset done");
        ticket_enable_setting = 1'b1;
        id_field_setting = 1'b1;
        skhc_host_model_inst.set_cts(1'b0);
        repeat (6) @(posedge clk);
        #2 out_byte = 8'hA5;
        out_valid = 1'b1;
        repeat (8) @(posedge clk);
        cmp("out_ready", 8'h00, {7'h00, out_ready});
        cmp("id_line", 8'h01, {7'h00, ticket_id_line});
        cmp("tare_lines", 8'h00, {7'h00, ticket_tare_lines});
        skhc_host_model_inst.set_cts(1'b1);
        taken = 1'b0;
        for (int i = 0; i < 40 && !taken; i++)
        begin
            @(posedge clk);
            taken = (out_ready === 1'b1);
        end
        if (!taken)
            timed_out("out_ready");
        #2 out_valid = 1'b0;
        id_field_setting = 1'b0;
        for (int i = 0; i < 12 * BIT_C && rx_count === 8'h00; i++)
            @(posedge clk);
        if (rx_count === 8'h00)
            timed_out("rx_byte");
        cmp("rx_byte", 8'hA5, rx_byte);
        cmp("id_line", 8'h00, {7'h00, ticket_id_line});
        $display("test ticket done");
        give_verdict();
    end
endmodule
`default_nettype wire
